// [src/rtcawd_top.sv]
// Real-time clock with alarm, watchdog and masked interrupt output on an APB slave.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rtcawd_cfg.svh"
module rtcawd_top (
  // System.
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Crystal and event inputs.
  input wire logic xtal_32k_i,
  input wire logic user_io_pin_i,
  input wire logic conversion_ready_i,
  input wire logic low_digital_supply_i,
  input wire logic low_pump_output_i,
  // Outputs.
  output logic int_o,
  output logic reset_o,
  output logic wake_o
);
  rtcawd_pkg::rtcawd_state_t s_reg;
  rtcawd_pkg::rtcawd_state_t s_next;
  logic xtal_rise;
  logic tick;
  logic setup;
  logic wr;
  logic [5:0] ev;
  logic low_digital_supply_flag;
  logic low_pump_output_flag;
  logic conversion_ready_flag;
  logic user_io_pin;

  // Register index decode, used for both reads and writes.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Unmapped addresses answer with an error; reads return zero and writes are dropped.
  function automatic logic mapped(input logic [11:0] a);
    mapped = 1'b0;
    if (hit(a, `RTCAWD_OFF_SEC)) begin
      mapped = 1'b1;
    end
    if (hit(a, `RTCAWD_OFF_SUB)) begin
      mapped = 1'b1;
    end
    if (hit(a, `RTCAWD_OFF_ALARM)) begin
      mapped = 1'b1;
    end
    if (hit(a, `RTCAWD_OFF_CTRL)) begin
      mapped = 1'b1;
    end
    if (hit(a, `RTCAWD_OFF_STATUS)) begin
      mapped = 1'b1;
    end
    if (hit(a, `RTCAWD_OFF_MASK)) begin
      mapped = 1'b1;
    end
    if (hit(a, `RTCAWD_OFF_WDSVC)) begin
      mapped = 1'b1;
    end
  endfunction

  // Shifts a pin into its three-stage synchroniser.
  function automatic logic [2:0] shift3(input logic [2:0] q, input logic d);
    shift3 = {q[1:0], d};
  endfunction

  // A synchronised level is trusted once the second and third stages agree.
  function automatic logic agree(input logic [2:0] q);
    agree = (q[1] == q[2]);
  endfunction

  // A level input counts as high once both late stages hold it.
  function automatic logic steady_high(input logic [2:0] q);
    steady_high = q[2] & q[1];
  endfunction

  // Rising edge of a settled level against its value one cycle earlier.
  function automatic logic edge_up(input logic prev, input logic cur);
    edge_up = cur & ~prev;
  endfunction

  // The alarm compares only while it is armed.
  function automatic logic alarm_due(input rtcawd_pkg::rtcawd_state_t st);
    alarm_due = st.ctrl[`RTCAWD_CTRL_ADE] && (st.sec[19:0] == st.alarm);
  endfunction

  // Pin level of the interrupt output for a given status, mask and polarity.
  function automatic logic irq_level(input logic [5:0] st, input logic [5:0] msk, input logic pol);
    irq_level = (|(st & ~msk)) ^ pol;
  endfunction

  // Reset output is active while the watchdog pulse runs or the supply is low.
  function automatic logic rst_level(input logic [7:0] cnt, input logic low);
    rst_level = (cnt != 8'h00) | low;
  endfunction

  // Read data of one register; unmapped addresses read as zero.
  function automatic logic [31:0] read_word(input rtcawd_pkg::rtcawd_state_t st,
    input logic [11:0] a);
    read_word = 32'h0;
    case (a)
      `RTCAWD_OFF_SEC: read_word = st.sec;
      `RTCAWD_OFF_SUB: read_word = {24'h0, st.sub};
      `RTCAWD_OFF_ALARM: read_word = {12'h0, st.alarm};
      `RTCAWD_OFF_CTRL: read_word = {29'h0, st.ctrl};
      `RTCAWD_OFF_STATUS: read_word = {26'h0, st.status};
      `RTCAWD_OFF_MASK: read_word = {26'h0, st.mask};
      `RTCAWD_OFF_WDSVC: read_word = 32'h0;
      default: read_word = 32'h0;
    endcase
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.xtal_sync = shift3(s_reg.xtal_sync, xtal_32k_i);
    s_next.user_io_pin_sync = shift3(s_reg.user_io_pin_sync, user_io_pin_i);
    s_next.low_digital_supply_flag_sync = shift3(s_reg.low_digital_supply_flag_sync, low_digital_supply_i);
    s_next.low_pump_output_flag_sync = shift3(s_reg.low_pump_output_flag_sync, low_pump_output_i);
    s_next.conversion_ready_flag_sync = shift3(s_reg.conversion_ready_flag_sync, conversion_ready_i);

    // Pin edges are taken from the settled level only.
    user_io_pin = s_reg.user_io_pin_last;
    if (agree(s_reg.user_io_pin_sync)) begin
      user_io_pin = s_reg.user_io_pin_sync[2];
    end
    s_next.user_io_pin_last = user_io_pin;
    low_digital_supply_flag = steady_high(s_reg.low_digital_supply_flag_sync);
    low_pump_output_flag = steady_high(s_reg.low_pump_output_flag_sync);
    conversion_ready_flag = steady_high(s_reg.conversion_ready_flag_sync);
    s_next.conversion_ready_flag_last = conversion_ready_flag;

    // The crystal edge is taken between the second and third stages.
    xtal_rise = s_reg.xtal_sync[1] & ~s_reg.xtal_sync[2];
    tick = 1'b0;
    if (xtal_rise) begin
      if (s_reg.xdiv == `RTCAWD_SUB_DIV - 8'h01) begin
        s_next.xdiv = 8'h00;
        tick = 1'b1;
      end else begin
        s_next.xdiv = s_reg.xdiv + 8'h01;
      end
    end

    // Bus: one access phase with ready follows each setup cycle.
    setup = psel_i & ~penable_i;
    wr = psel_i & penable_i & pwrite_i & s_reg.pready;
    s_next.pready = setup;
    s_next.pslverr = 1'b0;
    s_next.rdata = 32'h0;
    s_next.wake = 1'b0;

    // Time advances; a software write below overrides in the same cycle.
    if (tick) begin
      s_next.sub = s_reg.sub + 8'h01;
      if (s_reg.sub == 8'hff) begin
        s_next.sec = s_reg.sec + 32'h1;
      end
    end

    // Event sources.
    ev = 6'h0;
    ev[`RTCAWD_ST_CONVERSION_READY_FLAG] = edge_up(s_reg.conversion_ready_flag_last, conversion_ready_flag);
    ev[`RTCAWD_ST_USER_IO_PIN_RISE] = edge_up(s_reg.user_io_pin_last, user_io_pin);
    ev[`RTCAWD_ST_USER_IO_PIN_FALL] = edge_up(user_io_pin, s_reg.user_io_pin_last);
    ev[`RTCAWD_ST_LOW_DIGITAL_SUPPLY_FLAG] = low_digital_supply_flag;
    ev[`RTCAWD_ST_LOW_PUMP_OUTPUT_FLAG] = low_pump_output_flag;
    if (tick && alarm_due(s_reg)) begin
      ev[`RTCAWD_ST_ALARM] = 1'b1;
      s_next.ctrl[`RTCAWD_CTRL_ADE] = 1'b0;
      s_next.wake = 1'b1;
    end

    // Watchdog counts crystal ticks; timeout is 500 ms plus up to one tick of phase.
    if (s_reg.ctrl[`RTCAWD_CTRL_WDE] && tick) begin
      if (s_reg.wd_cnt == 8'(`RTCAWD_WD_TICKS)) begin
        s_next.wd_cnt = 8'h00;
        s_next.rst_cnt = 8'(`RTCAWD_RST_TICKS);
      end else begin
        s_next.wd_cnt = s_reg.wd_cnt + 8'h01;
      end
    end
    if (s_reg.rst_cnt != 8'h00 && tick) begin
      s_next.rst_cnt = s_reg.rst_cnt - 8'h01;
    end

    // Register writes.
    if (wr) begin
      if (hit(paddr_i, `RTCAWD_OFF_SEC)) begin
        s_next.sec = pwdata_i;
      end

      if (hit(paddr_i, `RTCAWD_OFF_SUB)) begin
        s_next.sub = pwdata_i[7:0];
      end

      if (hit(paddr_i, `RTCAWD_OFF_ALARM)) begin
        s_next.alarm = pwdata_i[19:0];
      end

      if (hit(paddr_i, `RTCAWD_OFF_CTRL)) begin
        s_next.ctrl = pwdata_i[2:0];
        if (!pwdata_i[`RTCAWD_CTRL_WDE]) begin
          s_next.wd_cnt = 8'h00;
        end else if (!s_reg.ctrl[`RTCAWD_CTRL_WDE]) begin
          s_next.wd_cnt = 8'h00;
        end
      end

      if (hit(paddr_i, `RTCAWD_OFF_MASK)) begin
        s_next.mask = pwdata_i[5:0];
      end

      if (hit(paddr_i, `RTCAWD_OFF_WDSVC)) begin
        s_next.wd_cnt = 8'h00;
      end
    end

    // Status is write-one-to-clear; a new event in the same cycle wins.
    s_next.status = s_reg.status;
    if (wr && hit(paddr_i, `RTCAWD_OFF_STATUS)) begin
      s_next.status = s_reg.status & ~pwdata_i[5:0];
    end
    s_next.status = s_next.status | ev;

    // Read data and the error response are launched together with ready.
    if (setup) begin
      s_next.pslverr = ~mapped(paddr_i);
      if (!pwrite_i) begin
        s_next.rdata = read_word(s_reg, paddr_i);
      end
    end

    // Mask bit set means the source is blocked.
    s_next.irq = irq_level(s_next.status, s_next.mask, s_next.ctrl[`RTCAWD_CTRL_POL]);
    s_next.rst_out = rst_level(s_next.rst_cnt, low_digital_supply_flag);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg.xtal_sync <= 3'h0;
      s_reg.user_io_pin_sync <= 3'h0;
      s_reg.user_io_pin_last <= 1'b0;
      s_reg.xdiv <= 8'h00;
      s_reg.sub <= 8'h00;
      s_reg.sec <= 32'h0;
      s_reg.alarm <= 20'h0;
      s_reg.ctrl <= `RTCAWD_CTRL_RST;
      s_reg.status <= 6'h0;
      s_reg.mask <= `RTCAWD_MASK_RST;
      s_reg.low_digital_supply_flag_sync <= 3'h0;
      s_reg.low_pump_output_flag_sync <= 3'h0;
      s_reg.conversion_ready_flag_sync <= 3'h0;
      s_reg.conversion_ready_flag_last <= 1'b0;
      s_reg.wd_cnt <= 8'h00;
      s_reg.rst_cnt <= 8'h00;
      s_reg.rdata <= 32'h0;
      s_reg.pready <= 1'b0;
      s_reg.pslverr <= 1'b0;
      s_reg.irq <= 1'b0;
      s_reg.rst_out <= 1'b0;
      s_reg.wake <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata_o = s_reg.rdata;
  assign pready_o = s_reg.pready;
  assign pslverr_o = s_reg.pslverr;
  assign int_o = s_reg.irq;
  assign reset_o = s_reg.rst_out;
  assign wake_o = s_reg.wake;
endmodule

// [src/rtcawd_cfg.svh]
// Offsets, field positions, reset values and timing counts of the clock, alarm and watchdog.
`ifndef RTCAWD_CFG_SVH
`define RTCAWD_CFG_SVH
`define RTCAWD_OFF_SEC 12'h000
`define RTCAWD_OFF_SUB 12'h004
`define RTCAWD_OFF_ALARM 12'h008
`define RTCAWD_OFF_CTRL 12'h00c
`define RTCAWD_OFF_STATUS 12'h010
`define RTCAWD_OFF_MASK 12'h014
`define RTCAWD_OFF_WDSVC 12'h018
`define RTCAWD_CTRL_ADE 0
`define RTCAWD_CTRL_WDE 1
`define RTCAWD_CTRL_POL 2
`define RTCAWD_ST_CONVERSION_READY_FLAG 0
`define RTCAWD_ST_ALARM 1
`define RTCAWD_ST_USER_IO_PIN_RISE 2
`define RTCAWD_ST_USER_IO_PIN_FALL 3
`define RTCAWD_ST_LOW_DIGITAL_SUPPLY_FLAG 4
`define RTCAWD_ST_LOW_PUMP_OUTPUT_FLAG 5
`define RTCAWD_NSRC 6
`define RTCAWD_MASK_RST 6'h3e
`define RTCAWD_CTRL_RST 3'h0
`define RTCAWD_SUB_DIV 8'h80
`define RTCAWD_WD_TIMEOUT_MS 500
`define RTCAWD_WD_RESET_MS 250
`define RTCAWD_TICK_HZ 256
`define RTCAWD_WD_TICKS ((`RTCAWD_WD_TIMEOUT_MS * `RTCAWD_TICK_HZ) / 1000)
`define RTCAWD_RST_TICKS ((`RTCAWD_WD_RESET_MS * `RTCAWD_TICK_HZ) / 1000)
`endif

// [src/rtcawd_pkg.sv]
// Types of the clock, alarm, watchdog and interrupt block.
package rtcawd_pkg;
  typedef struct packed {
    logic [2:0] xtal_sync;
    logic [2:0] user_io_pin_sync;
    logic user_io_pin_last;
    logic [7:0] xdiv;
    logic [7:0] sub;
    logic [31:0] sec;
    logic [19:0] alarm;
    logic [2:0] ctrl;
    logic [5:0] status;
    logic [5:0] mask;
    logic [2:0] low_digital_supply_flag_sync;
    logic [2:0] low_pump_output_flag_sync;
    logic [2:0] conversion_ready_flag_sync;
    logic conversion_ready_flag_last;
    logic [7:0] wd_cnt;
    logic [7:0] rst_cnt;
    logic [31:0] rdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic rst_out;
    logic wake;
  } rtcawd_state_t;
endpackage

// [testbench/rtcawd_properties.sv]
// Bus, supply reset and wake pulse properties of the timekeeping block.
`timescale 1ns/1ps
module rtcawd_props (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic low_digital_supply_i,
  input wire logic reset_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_access; psel_i && penable_i && pready_o; endsequence
  property p_answer; s_setup |=> s_access; endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_single; s_access |=> !pready_o; endproperty
  a_single: assert property (p_single) else $error("ready held");
  property p_idle; !psel_i |-> !pready_o; endproperty
  a_idle: assert property (p_idle) else $error("ready without select");
  property p_err; pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error read");
  property p_mapped;
    psel_i && penable_i && pready_o && paddr_i < 12'h01c && paddr_i[1:0] == 2'h0 |-> !pslverr_o;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error on mapped");
  property p_unmapped;
    psel_i && penable_i && pready_o && paddr_i >= 12'h01c |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error unmapped");
  property p_wake; wake_o |=> !wake_o; endproperty
  a_wake: assert property (p_wake) else $error("wake not a pulse");
  property p_lowrst; low_digital_supply_i [*6] |-> reset_o; endproperty
  a_lowrst: assert property (p_lowrst) else $error("no reset on low supply");
endmodule

// [testbench/rtcawd_host_model.sv]
// Interrupt receiver of the host controller.
`timescale 1ns/1ps
module rtcawd_host_model (
  input wire logic int_i,
  input wire logic active_low_i,
  output logic irq_o
);
  assign irq_o = int_i ^ active_low_i;
endmodule

// [testbench/test_rtcawd_top.sv]
// Self-checking bench of the clock, alarm and interrupt block.
`timescale 1ns/1ps
`include "rtcawd_cfg.svh"
module test_rtcawd_top;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, xtal = 1'b0, pol = 1'b0;
  logic psel, pen, pwr, pin, conversion_ready_flag, lowd, lowp, pready, pslverr, int_o, rst_o, wake, irq, err;
  int wd_n = 0, wd_len = 0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdat = 32'h0, rd, s, prdata;
  logic [32:0] notes[$];
  int mismatches = 0, checked = 0, seed = 32'h7080, wakes = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) xtal <= ~xtal;
  always @(posedge clk_sys_i) if (wake === 1'b1) wakes++;
  rtcawd_top dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .xtal_32k_i(xtal), .user_io_pin_i(pin),
    .conversion_ready_i(conversion_ready_flag), .low_digital_supply_i(lowd), .low_pump_output_i(lowp),
    .int_o(int_o), .reset_o(rst_o), .wake_o(wake));
  rtcawd_host_model host (.int_i(int_o), .active_low_i(pol), .irq_o(irq));
  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    if (!w) notes.push_back({c, d});
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_irq(input logic e);
    for (int k = 0; k < 1000 && irq !== e; k++) @(posedge clk_sys_i);
    cmp("irq", {31'h0, e}, {31'h0, irq});
    if (irq !== e) end_of_test();
  endtask
  always @(posedge clk_sys_i) if (pready === 1'b1 && psel && pen && !pwr && notes.size() > 0) begin
    if (notes[0][32]) cmp("prdata", notes[0][31:0], prdata);
    void'(notes.pop_front());
  end
  initial begin
    {psel, pen, pwr, pin, conversion_ready_flag, lowd, lowp} = 7'h0;
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    apb(0, 12'h014, 32'h3e, 1);
    apb(0, 12'h00c, 32'h0, 1);
    apb(0, 12'hffc, 32'h0, 1);
    cmp("pslverr", 32'h1, {31'h0, err});
    conversion_ready_flag <= 1'b1;
    wait_irq(1'b1);
    apb(1, 12'h00c, 32'h4, 0);
    pol <= 1'b1;
    @(posedge clk_sys_i);
    wait_irq(1'b1);
    apb(1, 12'h010, 32'h1, 0);
    wait_irq(1'b0);
    apb(1, 12'h014, 32'h3f, 0);
    conversion_ready_flag <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    conversion_ready_flag <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    cmp("irq", 32'h0, {31'h0, irq});
    apb(1, 12'h014, 32'h0, 0);
    wait_irq(1'b1);
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h010, 32'h3f, 0);
      wait_irq(1'b0);
      case (i)
        0: pin <= 1'b1;
        1: pin <= 1'b0;
        2: lowd <= 1'b1;
        default: lowp <= 1'b1;
      endcase
      wait_irq(1'b1);
      apb(0, 12'h010, 32'h1 << (i + 2), 1);
      {lowd, lowp} <= 2'b00;
      repeat (4) @(posedge clk_sys_i);
    end
    s = $random(seed) & 32'h7fffffff;
    apb(1, 12'h010, 32'h3f, 0);
    apb(1, 12'h000, s, 0);
    apb(1, 12'h004, 32'hff, 0);
    apb(1, 12'h008, (s + 32'h1) & 32'hfffff, 0);
    apb(1, 12'h00c, 32'h1, 0);
    pol <= 1'b0;
    rd = 32'hff;
    for (int k = 0; k < 1000 && rd === 32'hff; k++) apb(0, 12'h004, 32'h0, 0);
    cmp("sub", 32'h0, rd);
    if (rd === 32'hff) end_of_test();
    apb(0, 12'h000, s + 32'h1, 1);
    wait_irq(1'b1);
    apb(0, 12'h010, 32'h2, 1);
    apb(0, 12'h00c, 32'h0, 1);
    cmp("wake", 32'h1, wakes);
    apb(1, 12'h00c, 32'h2, 0);
    for (int i = 0; i < 3; i++) begin
      repeat (200) @(posedge clk_sys_i);
      apb(1, 12'h018, 32'h0, 0);
    end
    while (rst_o !== 1'b1 && wd_n < 60000) begin
      @(posedge clk_sys_i);
      wd_n++;
    end
    cmp("wd_timeout", 32'h1, {31'h0, wd_n >= `RTCAWD_WD_TICKS * 256 &&
      wd_n <= 3 * `RTCAWD_WD_TICKS * 128});
    if (rst_o !== 1'b1) end_of_test();
    while (rst_o === 1'b1 && wd_len < 20000) begin
      @(posedge clk_sys_i);
      wd_len++;
    end
    cmp("wd_reset", 32'h1, {31'h0, wd_len >= `RTCAWD_RST_TICKS * 256 - 4 &&
      wd_len <= `RTCAWD_RST_TICKS * 256 + 4});
    apb(1, 12'h00c, 32'h0, 0);
    repeat (200) @(posedge clk_sys_i);
    cmp("reset", 32'h0, {31'h0, rst_o});
    end_of_test();
  end
endmodule
bind rtcawd_top rtcawd_props u_props (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .low_digital_supply_i(low_digital_supply_i), .reset_o(reset_o), .wake_o(wake_o));
